// ---- design/switch_output_ctrl.sv ----
/*
 * switch output controller: one open/closed contact driven from a function
 * selector (forced open, forced closed, diagnostic, limit, discrete block),
 * with switching delays, alarm fallback, inversion and a readable state.
 * assumes measured values, discrete block outputs and event levels come from
 * logic on the same clock; registers are reached over AXI4-Lite.
 *
// Behaviour
// - function off: output always open, whatever happens.
// - function on: output always closed, whatever happens.
// - off and on settings simulate the output independent of process.
// - diagnostic mode: closed, opened only while a qualifying event is active.
// - diagnostic selector alarm, alarm or warning, warning; default alarm.
// - limit mode: closed normally, opened by threshold crossings.
// - on above off: close while value exceeds the on threshold.
// - on above off: open once value drops below the off threshold.
// - on below off: close while value is below the on threshold.
// - on below off: open once value rises above the off threshold.
// - discrete mode follows a chosen block: none, two diagnostic, four plain.
// - limit mode with a variable: closing delayed 0.0 to 100.0 s.
// - limit mode with a variable: opening delayed 0.0 to 100.0 s.
// - limit or discrete mode under alarm: actual, open or closed; default open.
// - present switch state is readable.
// - invert swaps open and closed for every behaviour; default off.
 */
`timescale 1ns/1ps
module switch_output_ctrl import switch_output_pkg::*; #(
   parameter int TICK = TICK_CYC
) (
   input  wire logic                     i_sys_clk,   // 25 MHz clock
   input  wire logic                     i_reset_n,   // sync reset, active low
   input  wire logic [NUM_SRC-1:0][31:0] i_meas,      // signed measured values
   input  wire logic [NUM_SRC-1:0]       i_do_block,  // discrete block outputs
   input  wire logic                     i_alarm,     // alarm event active
   input  wire logic                     i_warning,   // warning event active
   output logic                          o_switch,    // 1 = contact conductive
   input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [ADDR_W-1:0]        s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready
);
   // ------------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------------
   typedef struct packed {
      logic [31:0]       ctrl;
      logic [31:0]       on_thr;
      logic [31:0]       off_thr;
      logic [DLY_W-1:0]  on_dly;
      logic [DLY_W-1:0]  off_dly;
      logic              hyst;
      logic              pre_inv;
      logic              sw;
      logic [ADDR_W-1:0] awaddr;
      logic              aw_got;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              w_got;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [31:0]       rdata;
      logic              awrdy;
      logic              wrdy;
      logic              ardy;
   } ctrl_st_t;
   ctrl_st_t q, d;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [DLY_W-1:0] clamp(input logic [31:0] v);
      return (v > 32'(DLY_MAX)) ? DLY_MAX : v[DLY_W-1:0];
   endfunction

   // ------------------------------------------------------------------------
   // field decode
   // ------------------------------------------------------------------------
   logic [2:0]  func;
   logic [1:0]  diag_sel, fallback;
   logic [2:0]  do_sel, var_sel;
   logic        invert, var_on, delayed, event_hit, comp, wr_fire;
   logic signed [31:0] meas;
   logic [31:0] merged, rd_val;
   logic        rd_ok;

   assign func     = q.ctrl[FUNC_LSB  +: 3];
   assign diag_sel = q.ctrl[DIAG_LSB  +: 2];
   assign do_sel   = q.ctrl[DOSEL_LSB +: 3];
   assign fallback = q.ctrl[FB_LSB    +: 2];
   assign invert   = q.ctrl[INV_BIT];
   assign var_sel  = q.ctrl[VAR_LSB   +: 3];
   assign var_on   = var_sel != SEL_NONE && var_sel <= 3'(NUM_SRC);
   assign meas     = var_on ? i_meas[var_sel - 3'h1] : 32'sh0;

   // ------------------------------------------------------------------------
   // delay stage
   // ------------------------------------------------------------------------
   switch_delay #(.TICK(TICK)) u_delay (
      .i_sys_clk (i_sys_clk),
      .i_reset_n (i_reset_n),
      .i_target  (q.hyst),
      .i_bypass  (!(func == FN_LIMIT && var_on)),
      .i_on_dly  (q.on_dly),
      .i_off_dly (q.off_dly),
      .o_state   (delayed)
   );

   always_comb begin
      d       = q;
      wr_fire = q.aw_got && q.w_got && !q.bvalid;
      merged  = '0;
      rd_ok   = 1'b1;
      rd_val  = '0;

      // ---------------------------------------------------------------------
      // hysteresis on the selected variable
      // ---------------------------------------------------------------------
      if (func == FN_LIMIT && var_on) begin
         if ($signed(q.on_thr) >= $signed(q.off_thr)) begin
            if (meas > $signed(q.on_thr)) begin
               d.hyst = 1'b1;
            end else if (meas < $signed(q.off_thr)) begin
               d.hyst = 1'b0;
            end
         end else begin
            if (meas < $signed(q.on_thr)) begin
               d.hyst = 1'b1;
            end else if (meas > $signed(q.off_thr)) begin
               d.hyst = 1'b0;
            end
         end
         // anything between the thresholds leaves hyst alone
      end

      // ---------------------------------------------------------------------
      // function select
      // ---------------------------------------------------------------------
      case (diag_sel)
         DG_ALARM:      event_hit = i_alarm;
         DG_ALARM_WARN: event_hit = i_alarm || i_warning;
         DG_WARN:       event_hit = i_warning;
         default:       event_hit = i_alarm;
      endcase
      case (func)
         FN_OFF:   comp = 1'b0;
         FN_ON:    comp = 1'b1;
         FN_DIAG:  comp = !event_hit;
         FN_LIMIT: comp = var_on ? delayed : 1'b1;
         FN_DOUT:  comp = (do_sel != SEL_NONE && do_sel <= 3'(NUM_SRC))
                          ? i_do_block[do_sel - 3'h1] : 1'b0;
         default:  comp = 1'b0;
      endcase
      if ((func == FN_LIMIT || func == FN_DOUT) && i_alarm) begin
         case (fallback)
            FB_OPEN:   comp = 1'b0;
            FB_CLOSED: comp = 1'b1;
            default:   comp = comp;
         endcase
      end
      d.pre_inv = comp;
      d.sw      = comp ^ invert;

      // ---------------------------------------------------------------------
      // AXI4-Lite write: address and data taken in either order
      // ---------------------------------------------------------------------
      if (s_axi_awvalid && !q.aw_got && !q.bvalid) begin
         d.aw_got = 1'b1;
         d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !q.w_got && !q.bvalid) begin
         d.w_got = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      if (wr_fire) begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = RESP_OKAY;
         case ({q.awaddr[ADDR_W-1:2], 2'b00})
            ADDR_CTRL: begin
               merged = merge(q.ctrl, q.wdata, q.wstrb);
               d.ctrl = merged & CTRL_MASK;
            end
            ADDR_ON_THR:  d.on_thr  = merge(q.on_thr, q.wdata, q.wstrb);
            ADDR_OFF_THR: d.off_thr = merge(q.off_thr, q.wdata, q.wstrb);
            ADDR_ON_DLY: begin
               merged   = merge(32'(q.on_dly), q.wdata, q.wstrb);
               d.on_dly = clamp(merged);
            end
            ADDR_OFF_DLY: begin
               merged    = merge(32'(q.off_dly), q.wdata, q.wstrb);
               d.off_dly = clamp(merged);
            end
            ADDR_STATUS:  d.bresp = RESP_OKAY;
            default:      d.bresp = RESP_SLV;
         endcase
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end

      // ---------------------------------------------------------------------
      // AXI4-Lite read
      // ---------------------------------------------------------------------
      case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
         ADDR_CTRL:    rd_val = q.ctrl;
         ADDR_ON_THR:  rd_val = q.on_thr;
         ADDR_OFF_THR: rd_val = q.off_thr;
         ADDR_ON_DLY:  rd_val = 32'(q.on_dly);
         ADDR_OFF_DLY: rd_val = 32'(q.off_dly);
         ADDR_STATUS:  rd_val = {28'h0, i_alarm, q.hyst, q.pre_inv, q.sw};
         default:      rd_ok  = 1'b0;
      endcase
      if (s_axi_arvalid && !q.rvalid) begin
         d.rvalid = 1'b1;
         d.rdata  = rd_val;
         d.rresp  = rd_ok ? RESP_OKAY : RESP_SLV;
      end else if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      // readies come from flops so the bus sees no path from valid to ready
      d.awrdy = !d.aw_got && !d.bvalid;
      d.wrdy  = !d.w_got && !d.bvalid;
      d.ardy  = !d.rvalid;
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         q         <= '0;
         q.ctrl    <= CTRL_RESET;
         q.hyst    <= 1'b1;
         q.pre_inv <= 1'b0;
         q.awrdy   <= 1'b1;
         q.wrdy    <= 1'b1;
         q.ardy    <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign o_switch      = q.sw;
   assign s_axi_awready = q.awrdy;
   assign s_axi_wready  = q.wrdy;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = q.ardy;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;

   // ------------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);

   a_off_open: assert property (func == FN_OFF |=> o_switch == $past(invert))
      else $error("off mode not open");
   a_on_closed: assert property (func == FN_ON |=> o_switch == !$past(invert))
      else $error("on mode not closed");
   a_diag_event: assert property (func == FN_DIAG && !invert && diag_sel == DG_ALARM
      |=> o_switch == !$past(i_alarm))
      else $error("diag output wrong");
   a_diag_warn: assert property (func == FN_DIAG && !invert && diag_sel == DG_WARN
      |=> o_switch == !$past(i_warning))
      else $error("diag warning output wrong");
   a_limit_close: assert property (func == FN_LIMIT && var_on
      && $signed(q.on_thr) > $signed(q.off_thr) && meas > $signed(q.on_thr)
      |=> q.hyst)
      else $error("limit close missed");
   a_limit_drop: assert property (func == FN_LIMIT && var_on
      && $signed(q.on_thr) > $signed(q.off_thr) && meas < $signed(q.off_thr)
      |=> !q.hyst)
      else $error("limit drop open missed");
   a_limit_below: assert property (func == FN_LIMIT && var_on
      && $signed(q.on_thr) < $signed(q.off_thr) && meas < $signed(q.on_thr)
      |=> q.hyst)
      else $error("limit below close missed");
   a_limit_open: assert property (func == FN_LIMIT && var_on
      && $signed(q.on_thr) < $signed(q.off_thr) && meas > $signed(q.off_thr)
      |=> !q.hyst)
      else $error("limit open missed");
   a_hyst_hold: assert property (func == FN_LIMIT && var_on
      && $signed(q.on_thr) > $signed(q.off_thr) && meas <= $signed(q.on_thr)
      && meas >= $signed(q.off_thr) |=> $stable(q.hyst))
      else $error("hysteresis lost");
   a_on_wait: assert property (func == FN_LIMIT && var_on && q.on_dly != '0
      && $rose(q.hyst) && !delayed |=> !delayed)
      else $error("closing delay skipped");
   a_off_wait: assert property (func == FN_LIMIT && var_on && q.off_dly != '0
      && $fell(q.hyst) && delayed |=> delayed)
      else $error("opening delay skipped");
   a_alarm_fall: assert property (func == FN_DOUT && i_alarm && fallback == FB_OPEN
      |=> o_switch == $past(invert))
      else $error("fallback not open");
   a_alarm_closed: assert property ((func == FN_LIMIT || func == FN_DOUT) && i_alarm
      && fallback == FB_CLOSED |=> o_switch == !$past(invert))
      else $error("fallback not closed");
   a_dout_follow: assert property (func == FN_DOUT && !i_alarm && !invert
      && do_sel == 3'h1 |=> o_switch == $past(i_do_block[0]))
      else $error("discrete output not followed");
   a_invert_swap: assert property (1'b1 |=> (o_switch ^ q.pre_inv) == $past(invert))
      else $error("invert not applied");
   a_status_read: assert property (s_axi_arvalid && !q.rvalid
      && {s_axi_araddr[ADDR_W-1:2], 2'b00} == ADDR_STATUS
      |=> s_axi_rvalid && s_axi_rdata[0] == $past(o_switch))
      else $error("status read wrong");
   a_bypass_dly: assert property (func == FN_LIMIT && !var_on
      |=> o_switch == !$past(invert) || $past(i_alarm))
      else $error("unassigned limit not closed");

   c_limit_sw: cover property (func == FN_LIMIT && var_on ##1 $changed(q.hyst));
   c_alarm_fb: cover property (func == FN_DOUT && i_alarm);
   c_write_rsp: cover property (s_axi_bvalid && s_axi_bready);
   c_diag_open: cover property (func == FN_DIAG && event_hit);
   c_dly_wait: cover property (func == FN_LIMIT && var_on && q.hyst != delayed);
endmodule // switch_output_ctrl

// ---- pkg/switch_output_pkg.sv ----
/*
 * constants for the switch output controller: register map, field positions,
 * selector encodings and the delay time base.
 * assumes a 25 MHz system clock and 32-bit AXI4-Lite register access.
 */
package switch_output_pkg;
   // ------------------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------------------
   localparam logic [7:0]  ADDR_CTRL    = 8'h00;
   localparam logic [7:0]  ADDR_ON_THR  = 8'h04;
   localparam logic [7:0]  ADDR_OFF_THR = 8'h08;
   localparam logic [7:0]  ADDR_ON_DLY  = 8'h0c;
   localparam logic [7:0]  ADDR_OFF_DLY = 8'h10;
   localparam logic [7:0]  ADDR_STATUS  = 8'h14;
   localparam int          ADDR_W       = 8;
   // ------------------------------------------------------------------------
   // control fields
   // ------------------------------------------------------------------------
   localparam int FUNC_LSB  = 0;
   localparam int DIAG_LSB  = 4;
   localparam int DOSEL_LSB = 8;
   localparam int FB_LSB    = 12;
   localparam int INV_BIT   = 16;
   localparam int VAR_LSB   = 20;
   localparam logic [31:0] CTRL_RESET = 32'h0000_1000;
   localparam logic [31:0] CTRL_MASK  = 32'h0071_3737;
   localparam logic [2:0] FN_OFF = 3'h0, FN_ON = 3'h1, FN_DIAG = 3'h2;
   localparam logic [2:0] FN_LIMIT = 3'h3, FN_DOUT = 3'h4;
   localparam logic [1:0] DG_ALARM = 2'h0, DG_ALARM_WARN = 2'h1, DG_WARN = 2'h2;
   localparam logic [1:0] FB_ACTUAL = 2'h0, FB_OPEN = 2'h1, FB_CLOSED = 2'h2;
   localparam logic [2:0] SEL_NONE = 3'h0;
   localparam int         NUM_SRC  = 6;
   // ------------------------------------------------------------------------
   // delays: tenths of a second, 0.0 .. 100.0 s
   // ------------------------------------------------------------------------
   localparam int          DLY_W      = 10;
   localparam logic [9:0]  DLY_MAX    = 10'h3e8;
   localparam int          CLK_HZ     = 25_000_000;
   localparam int          TICK_MS    = 100;
   localparam int          TICK_CYC   = CLK_HZ / 1000 * TICK_MS;
   localparam int          PRE_W      = 22;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLV   = 2'h2;
endpackage

// ---- design/switch_delay.sv ----
/*
 * delay stage: the output follows the target level after a programmable
 * number of time-base ticks, separately for closing and for opening.
 * assumes target and delays come from logic on the same clock.
 */
`timescale 1ns/1ps
module switch_delay import switch_output_pkg::*; #(
   parameter int TICK = TICK_CYC
) (
   input  wire logic             i_sys_clk,  // system clock
   input  wire logic             i_reset_n,  // sync reset, active low
   input  wire logic             i_target,   // wanted level, 1 = closed
   input  wire logic             i_bypass,   // follow target at once
   input  wire logic [DLY_W-1:0] i_on_dly,   // closing delay, 0.1 s units
   input  wire logic [DLY_W-1:0] i_off_dly,  // opening delay, 0.1 s units
   output logic                  o_state     // delayed level
);
   typedef struct packed {
      logic             state;
      logic [PRE_W-1:0] pre;
      logic [DLY_W-1:0] cnt;
   } dly_st_t;
   dly_st_t q, d;
   logic [DLY_W-1:0] lim;

   always_comb begin
      d   = q;
      lim = i_target ? i_on_dly : i_off_dly;
      if (i_bypass || i_target == q.state) begin
         // a pending change that falls back restarts its full delay
         d.pre   = '0;
         d.cnt   = '0;
         d.state = i_target;
      end else if (q.cnt >= lim) begin
         d.state = i_target;
         d.pre   = '0;
         d.cnt   = '0;
      end else if (q.pre == PRE_W'(TICK - 1)) begin
         d.pre = '0;
         d.cnt = q.cnt + DLY_W'(1);
      end else begin
         d.pre = q.pre + PRE_W'(1);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         q <= '{state: 1'b1, pre: '0, cnt: '0};
      end else begin
         q <= d;
      end
   end

   assign o_state = q.state;
endmodule // switch_delay

// ---- sim/load_circuit_model.sv ----
/*
 * behavioural model of the external load wired to the switch contact.
 * assumes the contact level comes from logic on the same clock.
 */
`timescale 1ns/1ps
module load_circuit_model (
   input  wire logic i_sys_clk,  // system clock
   input  wire logic i_reset_n,  // sync reset, active low
   input  wire logic i_contact,  // 1 = contact conductive
   output logic      o_load_on   // load energised
);
   // a relay-like load picks up one clock after the contact changes,
   // so the bench never relies on same-cycle contact timing
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_load_on <= 1'h0;
      end else begin
         o_load_on <= i_contact;
      end
   end
endmodule // load_circuit_model

// ---- sim/switch_output_controller_test.sv ----
/*
 * self-checking bench for the switch output controller: registers over
 * AXI4-Lite, events and measured values driven directly, contact seen by a load.
 * assumes a shortened time base of 4 cycles per 0.1 s.
 */
`timescale 1ns/1ps
module switch_output_controller_test import switch_output_pkg::*;;
   localparam int SIM_TICK  = 4;
   localparam int LIMIT_CYC = 20000;
   logic                     clk = 1'h0;
   logic                     rst_n = 1'h0;
   logic [NUM_SRC-1:0][31:0] meas = '0;
   logic [NUM_SRC-1:0]       do_block = '0;
   logic                     alarm = 1'h0;
   logic                     warning = 1'h0;
   logic                     sw;
   logic                     load_on;
   logic [ADDR_W-1:0]        awaddr = '0;
   logic [ADDR_W-1:0]        araddr = '0;
   logic [31:0]              wdata = '0;
   logic [31:0]              rdata;
   logic                     awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic                     arvalid = 1'h0, rready = 1'h0;
   logic                     awready, wready, bvalid, arready, rvalid;
   logic [1:0]               bresp, rresp;
   int                       fails = 0;
   int                       check_count = 0;
   int                       cyc = 0;

   always #20 clk = ~clk;

   switch_output_ctrl #(.TICK(SIM_TICK)) uut (
      .i_sys_clk(clk), .i_reset_n(rst_n), .i_meas(meas), .i_do_block(do_block),
      .i_alarm(alarm), .i_warning(warning), .o_switch(sw),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   load_circuit_model load (.i_sys_clk(clk), .i_reset_n(rst_n), .i_contact(sw),
                            .o_load_on(load_on));

   // ---------------------------------------------------------------
   // compare and bus tasks
   // ---------------------------------------------------------------
   task automatic check_bit(input string what, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_word(input string what, input logic [31:0] exp,
                             input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                            output logic [1:0] resp);
      logic aw_done;
      logic w_done;
      @(posedge clk);
      aw_done = 1'h0;
      w_done  = 1'h0;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      while (!(aw_done && w_done)) begin
         @(posedge clk);
         if (!aw_done && awready === 1'h1) begin
            aw_done = 1'h1;
            awvalid <= 1'h0;
         end
         if (!w_done && wready === 1'h1) begin
            w_done = 1'h1;
            wvalid <= 1'h0;
         end
      end
      @(posedge clk);
      while (bvalid !== 1'h1) @(posedge clk);
      resp = bresp;
      bready <= 1'h0;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                           output logic [1:0] resp);
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      @(posedge clk);
      while (arready !== 1'h1) @(posedge clk);
      arvalid <= 1'h0;
      @(posedge clk);
      while (rvalid !== 1'h1) @(posedge clk);
      d = rdata;
      resp = rresp;
      rready <= 1'h0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_write(a, d, r);
      check_word("bresp", 32'h0, {30'h0, r});
   endtask

   task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(a, d, r);
      check_word("rdata", exp, d);
      check_word("rresp", 32'h0, {30'h0, r});
   endtask

   function automatic logic [31:0] ctrl(input logic [2:0] fn, input logic [1:0] dg,
      input logic [2:0] ds, input logic [1:0] fb, input logic inv, input logic [2:0] vr);
      return {9'h0, vr, 3'h0, inv, 2'h0, fb, 1'h0, ds, 2'h0, dg, 1'h0, fn};
   endfunction

   // the load lags the contact; six cycles covers every path without a delay
   task automatic check_sw(input logic e);
      repeat (6) @(posedge clk);
      check_bit("switch", e, load_on);
   endtask

   task automatic lim(input logic [31:0] v, input logic e);
      meas[0] <= v;
      check_sw(e);
   endtask

   task report_and_stop;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT_CYC) begin
         fails++;
         report_and_stop();
      end
   end

   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin : main
      logic [31:0] d;
      logic [1:0]  r;
      logic [5:0]  pat;
      logic        exp_sw;
      repeat (8) @(posedge clk);
      rst_n <= 1'h1;
      rd_check(ADDR_CTRL, CTRL_RESET);
      rd_check(ADDR_ON_DLY, 32'h0);
      alarm    <= 1'h1;
      warning  <= 1'h1;
      do_block <= 6'h3f;
      meas     <= {NUM_SRC{32'hc8}};
      check_sw(1'h0);
      wr(ADDR_CTRL, ctrl(FN_ON, DG_ALARM, 3'h1, FB_OPEN, 1'h0, 3'h1));
      check_sw(1'h1);
      axi_read(ADDR_STATUS, d, r);
      check_bit("status", 1'h1, d[0]);
      wr(ADDR_CTRL, ctrl(FN_ON, DG_ALARM, 3'h0, FB_OPEN, 1'h1, 3'h0));
      check_sw(1'h0);
      wr(ADDR_CTRL, ctrl(FN_OFF, DG_ALARM, 3'h0, FB_OPEN, 1'h1, 3'h0));
      check_sw(1'h1);
      for (int g = 0; g < 3; g++) begin
         wr(ADDR_CTRL, ctrl(FN_DIAG, 2'(g), 3'h0, FB_OPEN, 1'h0, 3'h0));
         for (int k = 0; k < 4; k++) begin
            alarm   <= k[0];
            warning <= k[1];
            exp_sw = !((g == 0 && k[0]) || (g == 1 && k != 0) || (g == 2 && k[1]));
            check_sw(exp_sw);
         end
      end
      alarm <= 1'h0;
      warning <= 1'h0;
      for (int s = 0; s < 7; s++) begin
         wr(ADDR_CTRL, ctrl(FN_DOUT, DG_ALARM, 3'(s), FB_OPEN, 1'h0, 3'h0));
         for (int p = 0; p < 2; p++) begin
            pat = p ? 6'h2a : 6'h15;
            do_block <= pat;
            check_sw(s == 0 ? 1'h0 : pat[s-1]);
         end
      end
      alarm <= 1'h1;
      for (int f = 0; f < 3; f++) begin
         wr(ADDR_CTRL, ctrl(FN_DOUT, DG_ALARM, 3'h1, 2'(f), 1'h0, 3'h0));
         for (int p = 0; p < 2; p++) begin
            do_block <= {6{p[0]}};
            check_sw(f == 0 ? p[0] : f == 2);
         end
      end
      alarm <= 1'h0;
      meas  <= '0;
      wr(ADDR_ON_THR, 32'h64);
      wr(ADDR_OFF_THR, 32'h32);
      wr(ADDR_CTRL, ctrl(FN_LIMIT, DG_ALARM, 3'h0, FB_OPEN, 1'h0, 3'h1));
      lim(32'hc8, 1'h1);
      lim(32'h4b, 1'h1);
      lim(32'hffff_ff9c, 1'h0);
      lim(32'h4b, 1'h0);
      lim(32'hc8, 1'h1);
      wr(ADDR_ON_THR, 32'h32);
      wr(ADDR_OFF_THR, 32'h64);
      lim(32'hc8, 1'h0);
      lim(32'h4b, 1'h0);
      wr(ADDR_ON_DLY, 32'h3);
      wr(ADDR_OFF_DLY, 32'h2);
      lim(32'h14, 1'h0);
      repeat (14) @(posedge clk);
      check_sw(1'h1);
      lim(32'hc8, 1'h1);
      repeat (10) @(posedge clk);
      check_sw(1'h0);
      wr(ADDR_CTRL, ctrl(FN_LIMIT, DG_ALARM, 3'h0, FB_OPEN, 1'h0, 3'h0));
      check_sw(1'h1);
      alarm <= 1'h1;
      check_sw(1'h0);
      alarm <= 1'h0;
      wr(ADDR_ON_DLY, 32'h0000_07ff);
      rd_check(ADDR_ON_DLY, 32'h3e8);
      axi_read(8'h18, d, r);
      check_word("rresp", 32'h2, {30'h0, r});
      check_word("rdata", 32'h0, d);
      axi_write(8'h1c, 32'hffff_ffff, r);
      check_word("bresp", 32'h2, {30'h0, r});
      report_and_stop();
   end
endmodule // switch_output_controller_test
